/* File: hw/eocmh_pkg.sv */
/*
 Constants shared by both ends of the message link: message identifiers,
 reserved ranges, octet bit positions, escape bytes and timing.
 Assumes a 200 MHz system clock common to both ends.
*/
// What this block does
// - Octet 3 bit 1 selects customer backoff mode
// - Octet 3 bit 0 requests restart after 5 s
// - Restart message is ID 15, octet 2 network
// - Default mode forces default backoff, no negotiation
// - IDs 64-88, 192-216 reserved segment management
// - IDs 112-119, 240-247 reserved proprietary
// - Terminals address proprietary messages individually
// - Repeater processes or forwards proprietary, never drops
// - Proprietary messages never use broadcast address
// - External data ID 120, port, then payload
// - Without external port, discard ID 120
// - ID 121 same layout; discard without interface
// - Port FF in ID 121 means SNMP
// - SNMP packet may span several messages
// - Unable to comply answered with ID 144
// - Reply octet 2 carries refused request ID
// - Own refusal bits stay; generic reply supplements
// - Screen escapes begin with byte 1B
// - Escape 2J clears screen, H homes cursor
// - Cursor digits, semicolon, H; origin row 1
// - Mean one-way delay at most 1.25 ms
// - Multi-pair adds at most 0.25 ms
package eocmh_pkg;
    typedef logic [7:0] eocmh_byte_t;

    localparam eocmh_byte_t ID_RESTART   = 8'h0F;
    localparam eocmh_byte_t ID_EXT_DATA  = 8'h78;
    localparam eocmh_byte_t ID_EXT_MGMT  = 8'h79;
    localparam eocmh_byte_t ID_UTC       = 8'h90;
    localparam eocmh_byte_t SEG_LO_A     = 8'h40;
    localparam eocmh_byte_t SEG_HI_A     = 8'h58;
    localparam eocmh_byte_t SEG_LO_B     = 8'hC0;
    localparam eocmh_byte_t SEG_HI_B     = 8'hD8;
    localparam eocmh_byte_t PROP_LO_A    = 8'h70;
    localparam eocmh_byte_t PROP_HI_A    = 8'h77;
    localparam eocmh_byte_t PROP_LO_B    = 8'hF0;
    localparam eocmh_byte_t PROP_HI_B    = 8'hF7;
    localparam eocmh_byte_t PORT_SNMP    = 8'hFF;
    localparam eocmh_byte_t ADDR_BCAST   = 8'h00;
    localparam eocmh_byte_t CH_ESC       = 8'h1B;
    localparam eocmh_byte_t CH_BRACKET   = 8'h5B;
    localparam eocmh_byte_t CH_SEMI      = 8'h3B;
    localparam eocmh_byte_t CH_ZERO      = 8'h30;
    localparam eocmh_byte_t CH_NINE      = 8'h39;
    localparam eocmh_byte_t CH_TWO       = 8'h32;
    localparam eocmh_byte_t CH_J         = 8'h4A;
    localparam eocmh_byte_t CH_H         = 8'h48;
    localparam eocmh_byte_t SCREEN_ORIGIN = 8'h01;
    localparam int          BIT_RESTART  = 0;
    localparam int          BIT_BACKOFF  = 1;
    localparam int          OCT_ID       = 1;
    localparam int          OCT_NET      = 2;
    localparam int          OCT_CUST     = 3;
    localparam int          OCT_PORT     = 2;

    // Timing: restart delay and latency budgets
    localparam int          CLK_PER_NS       = 5;
    localparam longint      RESTART_DELAY_MS = 5000;
    localparam longint      RESTART_CYCLES   = RESTART_DELAY_MS * 1000000 / CLK_PER_NS;
    localparam int          LATENCY_US_X100  = 125;
    localparam int          LATENCY_CYCLES   = LATENCY_US_X100 * 10000 / CLK_PER_NS;
    localparam int          MPAIR_US_X100    = 25;
    localparam int          MPAIR_CYCLES     = MPAIR_US_X100 * 10000 / CLK_PER_NS;

    // Reserved-range classifiers; the peer end uses only eocmh_is_prop
    function automatic logic eocmh_is_seg(input eocmh_byte_t id);
        return (id >= SEG_LO_A && id <= SEG_HI_A) || (id >= SEG_LO_B && id <= SEG_HI_B);
    endfunction

    function automatic logic eocmh_is_prop(input eocmh_byte_t id);
        return (id >= PROP_LO_A && id <= PROP_HI_A) || (id >= PROP_LO_B && id <= PROP_HI_B);
    endfunction
endpackage

/* File: hw/eocmh_link_if.sv */
/*
 Octet stream link between the local handler and its peer handler.
 Assumes both ends share clk; one octet per cycle when valid and ready.
*/
`timescale 1ns/10ps
interface eocmh_link_if (
    input wire logic clk      // System clock
);
    logic                      rx_valid;  // Octet toward device valid
    logic                      rx_ready;  // Device can take octet
    logic [7:0]                rx_data;   // Octet toward device
    logic                      rx_last;   // Final octet of message
    logic [7:0]                rx_addr;   // Destination address of message
    logic                      tx_valid;  // Octet from device valid
    logic                      tx_ready;  // Peer can take octet
    logic [7:0]                tx_data;   // Octet from device
    logic                      tx_last;   // Final octet of reply

    modport dev  (input rx_valid, rx_data, rx_last, rx_addr, tx_ready,
                  output rx_ready, tx_valid, tx_data, tx_last);
    modport peer (output rx_valid, rx_data, rx_last, rx_addr, tx_ready,
                  input rx_ready, tx_valid, tx_data, tx_last);
endinterface

/* File: hw/eocmh_device.sv */
/*
 Device end of the message handler: decodes received messages, holds the
 restart and backoff settings, passes external data out, tracks screen
 escapes and answers refused requests with the generic refusal.
 Assumes the peer presents whole messages, octet 1 being the identifier.
*/
`timescale 1ns/10ps
module eocmh_device #(
    parameter bit     HAS_EXT_DATA = 1'b1,              // External data port fitted
    parameter bit     HAS_EXT_MGMT = 1'b1,              // Management interface fitted
    parameter bit     IS_REPEATER  = 1'b0,              // Repeater role
    parameter longint RESTART_WAIT = eocmh_pkg::RESTART_CYCLES  // Restart delay
) (
    input  wire logic              clk,           // System clock
    input  wire logic              rst_b,         // Async reset, active low
    eocmh_link_if.dev              link,          // Peer message link
    output logic                   cust_backoff_sel, // Customer backoff selected
    output logic                   net_backoff_sel,  // Network backoff selected
    output logic                   backoff_default,  // Apply default, no negotiation
    output logic                   soft_restart,     // One-cycle restart pulse
    output logic                   ext_valid,        // External payload octet valid
    output eocmh_pkg::eocmh_byte_t ext_data,         // External payload octet
    output eocmh_pkg::eocmh_byte_t ext_port,         // Logical port of payload
    output logic                   ext_mgmt,         // Payload belongs to mgmt message
    output logic                   ext_snmp,         // Mgmt port carries SNMP
    output logic                   ext_snmp_end,     // Message end, SNMP may continue
    output logic                   prop_fwd,         // Proprietary octet forwarded
    output eocmh_pkg::eocmh_byte_t prop_data,        // Forwarded octet
    output logic                   screen_clear,     // Clear-screen escape seen
    output logic                   cursor_set,       // Cursor placement escape seen
    output eocmh_pkg::eocmh_byte_t cursor_row,       // Row, origin 1
    output eocmh_pkg::eocmh_byte_t cursor_col        // Column, origin 1
);
    import eocmh_pkg::*;

    typedef enum logic [2:0] {
        ESC_IDLE = 3'b001,
        ESC_OPEN = 3'b010,
        ESC_BODY = 3'b100
    } eocmh_esc_e;

    eocmh_byte_t msg_id;
    logic [3:0]  octet_no;
    logic        busy_reply;
    logic [1:0]  reply_idx;
    eocmh_byte_t reply_id;
    logic [39:0] restart_cnt;
    logic        restart_pend;
    eocmh_esc_e  esc_state;
    eocmh_byte_t num_a;
    eocmh_byte_t num_b;
    logic        got_semi;
    logic        got_two;

    wire logic        take   = link.rx_valid && link.rx_ready;
    wire eocmh_byte_t cur_id = (octet_no == 4'(OCT_ID)) ? link.rx_data : msg_id;
    // Accept octets only while the reply path is free; stalls the peer otherwise
    assign link.rx_ready = !busy_reply;

    // Octet position within message
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            octet_no <= 4'h1;
            msg_id   <= 8'h00;
        end else if (take) begin
            if (octet_no == 4'(OCT_ID)) msg_id <= link.rx_data;
            if (link.rx_last) octet_no <= 4'h1;
            else if (octet_no != 4'hF) octet_no <= octet_no + 4'h1;
        end
    end

    // Restart and backoff settings, held while powered
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cust_backoff_sel <= 1'b0;
            net_backoff_sel  <= 1'b0;
        end else if (take && msg_id == ID_RESTART) begin
            if (octet_no == 4'(OCT_NET)) net_backoff_sel <= link.rx_data[BIT_BACKOFF];
            if (octet_no == 4'(OCT_CUST))
                cust_backoff_sel <= link.rx_data[BIT_BACKOFF];
        end
    end
    assign backoff_default = !cust_backoff_sel;

    // Delayed soft restart; a repeat request restarts the wait
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            restart_pend <= 1'b0;
            restart_cnt  <= 40'h0;
            soft_restart <= 1'b0;
        end else begin
            soft_restart <= 1'b0;
            if (take && msg_id == ID_RESTART && octet_no == 4'(OCT_CUST)
                && link.rx_data[BIT_RESTART]) begin
                restart_pend <= 1'b1;
                restart_cnt  <= 40'(RESTART_WAIT - 1);
            end else if (restart_pend) begin
                if (restart_cnt == 40'h0) begin
                    restart_pend <= 1'b0;
                    soft_restart <= 1'b1;
                end else restart_cnt <= restart_cnt - 40'h1;
            end
        end
    end

    // External payload passthrough, discarded when unfitted
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ext_valid    <= 1'b0;
            ext_data     <= 8'h00;
            ext_port     <= 8'h00;
            ext_mgmt     <= 1'b0;
            ext_snmp_end <= 1'b0;
        end else begin
            ext_valid    <= 1'b0;
            ext_snmp_end <= 1'b0;
            if (take && ((msg_id == ID_EXT_DATA && HAS_EXT_DATA)
                      || (msg_id == ID_EXT_MGMT && HAS_EXT_MGMT))) begin
                if (octet_no == 4'(OCT_PORT)) begin
                    ext_port <= link.rx_data;
                    ext_mgmt <= (msg_id == ID_EXT_MGMT);
                end else if (octet_no > 4'(OCT_PORT)) begin
                    // One register stage keeps transfer delay far inside the budget
                    ext_valid    <= 1'b1;
                    ext_data     <= link.rx_data;
                    // Downstream reassembles SNMP across message ends
                    ext_snmp_end <= link.rx_last;
                end
            end
        end
    end
    assign ext_snmp = ext_mgmt && ext_port == PORT_SNMP;

    // Repeater forwards proprietary octets it does not consume
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            prop_fwd  <= 1'b0;
            prop_data <= 8'h00;
        end else begin
            prop_fwd  <= take && IS_REPEATER && eocmh_is_prop(cur_id)
                         && link.rx_addr != ADDR_BCAST;
            prop_data <= link.rx_data;
        end
    end

    // Refusal: segment IDs always, IDs 112-119 and 240-247 unless repeater
    wire logic refuse = eocmh_is_seg(cur_id) || (!IS_REPEATER && eocmh_is_prop(cur_id));
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            busy_reply <= 1'b0;
            reply_idx  <= 2'h0;
            reply_id   <= 8'h00;
        end else if (!busy_reply) begin
            if (take && link.rx_last && refuse) begin
                busy_reply <= 1'b1;
                reply_idx  <= 2'h0;
                reply_id   <= cur_id;
            end
        end else if (link.tx_ready) begin
            if (reply_idx == 2'h1) busy_reply <= 1'b0;
            reply_idx <= reply_idx + 2'h1;
        end
    end
    // Two-octet generic refusal; own refusal bits in other replies untouched
    assign link.tx_valid = busy_reply;
    assign link.tx_data  = (reply_idx == 2'h0) ? ID_UTC : reply_id;
    assign link.tx_last  = busy_reply && reply_idx == 2'h1;

    // Screen escape tracking on every octet after the identifier
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            esc_state    <= ESC_IDLE;
            num_a        <= 8'h00;
            num_b        <= 8'h00;
            got_semi     <= 1'b0;
            got_two      <= 1'b0;
            screen_clear <= 1'b0;
            cursor_set   <= 1'b0;
            cursor_row   <= SCREEN_ORIGIN;
            cursor_col   <= SCREEN_ORIGIN;
        end else begin
            screen_clear <= 1'b0;
            cursor_set   <= 1'b0;
            if (take && octet_no > 4'(OCT_ID)) begin
                unique case (esc_state)
                    ESC_IDLE: if (link.rx_data == CH_ESC) esc_state <= ESC_OPEN;
                    ESC_OPEN: begin
                        esc_state <= (link.rx_data == CH_BRACKET) ? ESC_BODY : ESC_IDLE;
                        num_a     <= 8'h00;
                        num_b     <= 8'h00;
                        got_semi  <= 1'b0;
                        got_two   <= 1'b0;
                    end
                    ESC_BODY: begin
                        if (link.rx_data >= CH_ZERO && link.rx_data <= CH_NINE) begin
                            got_two <= !got_semi && num_a == 8'h00 && link.rx_data == CH_TWO;
                            if (got_semi)
                                num_b <= 8'(num_b * 8'h0A + (link.rx_data - CH_ZERO));
                            else
                                num_a <= 8'(num_a * 8'h0A + (link.rx_data - CH_ZERO));
                        end else if (link.rx_data == CH_SEMI) begin
                            got_semi <= 1'b1;
                        end else begin
                            esc_state <= ESC_IDLE;
                            if (link.rx_data == CH_J && got_two)
                                screen_clear <= 1'b1;
                            else if (link.rx_data == CH_H) begin
                                // Missing numbers fall back to origin
                                cursor_set <= 1'b1;
                                cursor_row <= (num_a == 8'h00) ? SCREEN_ORIGIN : num_a;
                                cursor_col <= (num_b == 8'h00) ? SCREEN_ORIGIN : num_b;
                            end
                        end
                    end
                    default: esc_state <= ESC_IDLE;
                endcase
            end
        end
    end
endmodule // eocmh_device

/* File: hw/eocmh_peer.sv */
/*
 Peer end: sends one user message octet by octet over the link and takes
 reply octets. Refuses to send proprietary messages to broadcast.
 Assumes user holds msg fields steady while send_busy is high.
*/
`timescale 1ns/10ps
module eocmh_peer #(
    parameter int MAX_LEN = 16                       // Octets per message
) (
    input  wire logic              clk,               // System clock
    input  wire logic              rst_b,             // Async reset, active low
    eocmh_link_if.peer             link,              // Device link
    input  wire logic              send_req,          // Start a message, pulse
    input  wire eocmh_pkg::eocmh_byte_t send_addr,    // Destination address
    input  wire logic [4:0]        send_len,          // Octet count, 1..MAX_LEN
    input  wire logic [MAX_LEN*8-1:0] send_msg,       // Octets, first in low byte
    input  wire logic              reply_ready,       // User takes reply octets
    output logic                   send_busy,         // Message in flight
    output logic                   send_refused,      // Broadcast proprietary refused
    output logic                   reply_valid,       // Reply octet valid
    output eocmh_pkg::eocmh_byte_t reply_data,        // Reply octet
    output logic                   reply_last         // Final reply octet
);
    import eocmh_pkg::*;

    logic [4:0] idx;
    // Proprietary messages must carry an individual address
    wire logic  bad = eocmh_is_prop(send_msg[7:0])
                      && send_addr == ADDR_BCAST;

    // Send sequencer
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            send_busy    <= 1'b0;
            send_refused <= 1'b0;
            idx          <= 5'h00;
        end else begin
            send_refused <= 1'b0;
            if (!send_busy && send_req) begin
                send_refused <= bad;
                send_busy    <= !bad && send_len != 5'h00;
                idx          <= 5'h00;
            end else if (send_busy && link.rx_ready) begin
                if (idx == send_len - 5'h01) send_busy <= 1'b0;
                idx <= idx + 5'h01;
            end
        end
    end
    assign link.rx_valid = send_busy;
    assign link.rx_data  = send_msg[idx*8 +: 8];
    assign link.rx_last  = send_busy && idx == send_len - 5'h01;
    assign link.rx_addr  = send_addr;

    // Replies pass to the user through one register stage
    assign link.tx_ready = reply_ready;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            reply_valid <= 1'b0;
            reply_data  <= 8'h00;
            reply_last  <= 1'b0;
        end else begin
            reply_valid <= link.tx_valid && reply_ready;
            reply_data  <= link.tx_data;
            reply_last  <= link.tx_valid && link.tx_last && reply_ready;
        end
    end
endmodule // eocmh_peer

/* File: sim/eocmh_asserts.sv */
/*
 Concurrent checks on the octet link between the device and peer ends.
 Assumes it is instantiated beside the link interface, fed its signals.
*/
`timescale 1ns/10ps
module eocmh_asserts (
    input wire logic       clk,      // System clock
    input wire logic       rst_b,    // Async reset, active low
    input wire logic       rx_valid, // Octet toward device valid
    input wire logic       rx_ready, // Device can take octet
    input wire logic [7:0] rx_data,  // Octet toward device
    input wire logic       rx_last,  // Final octet of message
    input wire logic [7:0] rx_addr,  // Destination address
    input wire logic       tx_valid, // Reply octet valid
    input wire logic       tx_ready, // Peer takes reply octet
    input wire logic [7:0] tx_data,  // Reply octet
    input wire logic       tx_last   // Final reply octet
);
    import eocmh_pkg::*;

    logic        first;  // Next octet taken is an identifier
    eocmh_byte_t id_q;   // Identifier of message in flight
    logic        take;
    eocmh_byte_t cur_id;
    logic        seg;
    logic        prop;
    logic        ends;

    // Ranges coded apart from the package so a wrong bound there shows
    assign take   = rx_valid && rx_ready;
    assign cur_id = first ? rx_data : id_q;
    assign seg    = (cur_id >= 8'h40 && cur_id <= 8'h58) || (cur_id >= 8'hC0 && cur_id <= 8'hD8);
    assign prop   = (cur_id >= 8'h70 && cur_id <= 8'h77) || (cur_id >= 8'hF0 && cur_id <= 8'hF7);
    assign ends   = take && rx_last;

    // Track the identifier octet of each message
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            first <= 1'b1;
            id_q  <= 8'h00;
        end else if (take) begin
            first <= rx_last;
            if (first) begin
                id_q <= rx_data;
            end
        end
    end

    default clocking @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    a_seg_refuse: assert property (
        ends && seg |=> tx_valid && tx_data == ID_UTC) else $error("segment id not refused");
    a_prop_refuse: assert property (
        ends && prop |=> tx_valid && tx_data == ID_UTC) else $error("proprietary id not refused");
    a_utc_echo: assert property (
        ends && (seg || prop) ##1 tx_ready |=> tx_valid && tx_last && tx_data == $past(cur_id, 2))
        else $error("refusal does not echo request id");
    a_reply_start: assert property (
        $rose(tx_valid) |-> tx_data == ID_UTC && !tx_last) else $error("reply not led by refusal id");
    a_reply_hold: assert property (
        tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_last))
        else $error("reply octet dropped while stalled");
    a_reply_block: assert property (
        tx_valid |-> !rx_ready) else $error("device takes octets while replying");
    a_reply_done: assert property (
        tx_valid && tx_ready && tx_last |=> !tx_valid && rx_ready) else $error("reply overruns");
    a_known_quiet: assert property (
        ends && (cur_id == ID_RESTART || cur_id == ID_EXT_DATA || cur_id == ID_EXT_MGMT)
        |=> !tx_valid [*3]) else $error("supported message refused");
    a_prop_unicast: assert property (
        rx_valid && first && prop |-> rx_addr != ADDR_BCAST) else $error("proprietary broadcast");
endmodule // eocmh_asserts

/* File: sim/test_eoc_message_handler.sv */
/*
 Testbench joining the device and peer ends over the link interface.
 Assumes a shortened restart delay; drives the peer user side only.
*/
`timescale 1ns/10ps
module test_eoc_message_handler;
    import eocmh_pkg::*;

    localparam longint RW = 20;  // Short restart delay keeps the run brief

    logic clk = 1'b0, rst_b = 1'b0, send_req = 1'b0, reply_ready = 1'b1, refused;
    eocmh_byte_t send_addr = 8'h00, ext_d, ext_p;
    logic [4:0] send_len = 5'h01;
    logic [127:0] send_msg = '0;
    logic send_busy, send_refused, reply_valid, reply_last, cust_backoff_sel, net_backoff_sel;
    logic backoff_default, soft_restart, ext_valid, ext_mgmt, ext_snmp, ext_snmp_end, prop_fwd;
    logic screen_clear, cursor_set;
    eocmh_byte_t reply_data, ext_data, ext_port, prop_data, cursor_row, cursor_col;
    int failures = 0, compares = 0, cyc = 0, t_take = 0, t_rst = 0, n_rst = 0, n_ext = 0;
    int n_snmp = 0, n_end = 0, n_clr = 0, n_cur = 0, n_prop = 0, t_ext = 0, b0, b1, b2;
    eocmh_byte_t rep[$];
    eocmh_byte_t ids[12] = '{8'h40, 8'h58, 8'hC0, 8'hD8, 8'h70, 8'h77, 8'hF0, 8'hF7,
                             8'h3F, 8'h59, 8'h6F, 8'hF8};

    always #2.5 clk = ~clk;

    eocmh_link_if link (.clk(clk));
    eocmh_device #(.RESTART_WAIT(RW)) u_eocmh_device (.clk(clk), .rst_b(rst_b), .link(link),
        .cust_backoff_sel(cust_backoff_sel), .net_backoff_sel(net_backoff_sel),
        .backoff_default(backoff_default), .soft_restart(soft_restart), .ext_valid(ext_valid),
        .ext_data(ext_data), .ext_port(ext_port), .ext_mgmt(ext_mgmt), .ext_snmp(ext_snmp),
        .ext_snmp_end(ext_snmp_end), .prop_fwd(prop_fwd), .prop_data(prop_data),
        .screen_clear(screen_clear), .cursor_set(cursor_set), .cursor_row(cursor_row),
        .cursor_col(cursor_col));
    eocmh_peer #(.MAX_LEN(16)) u_eocmh_peer (.clk(clk), .rst_b(rst_b), .link(link),
        .send_req(send_req), .send_addr(send_addr), .send_len(send_len), .send_msg(send_msg),
        .reply_ready(reply_ready), .send_busy(send_busy), .send_refused(send_refused),
        .reply_valid(reply_valid), .reply_data(reply_data), .reply_last(reply_last));
    eocmh_asserts u_eocmh_asserts (.clk(clk), .rst_b(rst_b), .rx_valid(link.rx_valid),
        .rx_ready(link.rx_ready), .rx_data(link.rx_data), .rx_last(link.rx_last),
        .rx_addr(link.rx_addr), .tx_valid(link.tx_valid), .tx_ready(link.tx_ready),
        .tx_data(link.tx_data), .tx_last(link.tx_last));

    // Pulse outputs are counted here since they stand for one cycle only
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (link.rx_valid && link.rx_ready) t_take <= cyc;
        if (soft_restart) begin
            n_rst <= n_rst + 1;
            t_rst <= cyc;
        end
        if (ext_valid) begin
            n_ext <= n_ext + 1;
            t_ext <= cyc;
            n_snmp <= n_snmp + int'(ext_snmp && ext_mgmt);
            ext_d <= ext_data;
            ext_p <= ext_port;
        end
        if (ext_snmp_end) n_end <= n_end + 1;
        if (screen_clear) n_clr <= n_clr + 1;
        if (cursor_set) n_cur <= n_cur + 1;
        if (prop_fwd) n_prop <= n_prop + 1;
        if (reply_valid) rep.push_back(reply_data);
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One whole message from the peer user side, then let replies land
    task automatic send(input eocmh_byte_t a, input logic [4:0] l, input logic [127:0] m);
        int i;
        @(posedge clk);
        send_addr <= a;
        send_len <= l;
        send_msg <= m;
        send_req <= 1'b1;
        @(posedge clk);
        send_req <= 1'b0;
        #1;
        refused = send_refused;
        for (i = 0; i < 100 && send_busy !== 1'b0; i++) @(posedge clk) #1;
        chk(send_busy, 1'b0);
        repeat (8) @(posedge clk);
        #1;
    endtask

    task automatic end_sim;
        $display("Comparisons %0d, mismatches %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // Watchdog well beyond the expected run of under five hundred cycles
    initial begin
        #50000;
        failures++;
        end_sim;
    end

    initial begin
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        send(8'h02, 5'h03, 128'({8'h03, 8'h00, ID_RESTART}));
        chk(cust_backoff_sel, 1'b1);
        chk(backoff_default, 1'b0);
        repeat (30) @(posedge clk);
        #1;
        chk(n_rst, 1);
        chk(t_rst - t_take >= RW && t_rst - t_take <= RW + 2, 1'b1);
        send(8'h02, 5'h03, 128'({8'h00, 8'h02, ID_RESTART}));
        chk(net_backoff_sel, 1'b1);
        chk(cust_backoff_sel, 1'b0);
        chk(backoff_default, 1'b1);
        repeat (30) @(posedge clk);
        #1;
        chk(n_rst, 1);
        $display("Test restart and backoff done");
        // Range edges inside and just outside; first case stalls the reply
        for (int k = 0; k < 12; k++) begin
            rep.delete();
            @(posedge clk);
            reply_ready <= (k != 0);
            send(8'h02, 5'h01, {120'h0, ids[k]});
            @(posedge clk);
            reply_ready <= 1'b1;
            repeat (8) @(posedge clk);
            #1;
            chk(rep.size(), (k < 8) ? 2 : 0);
            if (k < 8) begin
                chk(rep[0], ID_UTC);
                chk(rep[1], ids[k]);
            end
        end
        rep.delete();
        send(ADDR_BCAST, 5'h01, {120'h0, 8'hF0});
        chk(refused, 1'b1);
        chk(rep.size(), 0);
        chk(n_prop, 0);
        $display("Test reserved ranges done");
        b0 = n_ext;
        send(8'h02, 5'h04, 128'({8'hAA, 8'h55, 8'h05, ID_EXT_DATA}));
        chk(n_ext - b0, 2);
        chk(t_ext - t_take <= LATENCY_CYCLES - MPAIR_CYCLES, 1'b1);
        chk({ext_p, ext_d, 7'h0, ext_mgmt}, {8'h05, 8'hAA, 8'h00});
        b0 = n_ext;
        b1 = n_snmp;
        b2 = n_end;
        send(8'h02, 5'h04, 128'({8'h02, 8'h01, PORT_SNMP, ID_EXT_MGMT}));
        send(8'h02, 5'h03, 128'({8'h03, PORT_SNMP, ID_EXT_MGMT}));
        chk(n_ext - b0, 3);
        chk(n_snmp - b1, 3);
        chk(n_end - b2, 2);
        chk({ext_p, ext_d}, {PORT_SNMP, 8'h03});
        $display("Test external messages done");
        send(8'h02, 5'h05, 128'({CH_J, CH_TWO, CH_BRACKET, CH_ESC, 8'h88}));
        chk(n_clr, 1);
        send(8'h02, 5'h08, 128'({CH_H, 8'h32, 8'h31, CH_SEMI, 8'h34, CH_BRACKET, CH_ESC, 8'h88}));
        chk({cursor_row, cursor_col}, {8'h04, 8'h0C});
        send(8'h02, 5'h04, 128'({CH_H, CH_BRACKET, CH_ESC, 8'h88}));
        chk(n_cur, 2);
        chk({cursor_row, cursor_col}, {SCREEN_ORIGIN, SCREEN_ORIGIN});
        $display("Test screen escapes done");
        end_sim;
    end
endmodule // test_eoc_message_handler
